// file: src/tcc_consts.svh
// constants of the thermometer control and chain unit
// assumes a 50 MHz core clock and byte-wide scratchpad locations
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_CLK_MHZ        50
`define TCC_T_PROG_US      10000

`define TCC_SP_TEMP_LSB    3'h0
`define TCC_SP_TEMP_MSB    3'h1
`define TCC_SP_HIGH_ALARM  3'h2
`define TCC_SP_LOW_ALARM   3'h3
`define TCC_SP_CONV_CONFIG 3'h4
`define TCC_SP_RSV5        3'h5
`define TCC_SP_RSV6        3'h6
`define TCC_SP_RSV7        3'h7

`define TCC_CFG_RES_HI     6
`define TCC_CFG_RES_LO     5
`define TCC_CFG_FIXED_MASK 8'h9f
`define TCC_CFG_FIXED_VAL  8'h1f
`define TCC_CFG_RESET      8'h7f
`define TCC_TH_RESET       8'h55
`define TCC_TL_RESET       8'h00
`define TCC_TEMP_RESET     16'h0550
`define TCC_RSV5_VAL       8'hff
`define TCC_RSV6_VAL       8'h0c
`define TCC_RSV7_VAL       8'h10

`define TCC_CMD_WR_SP      8'h4e
`define TCC_CMD_RD_SP      8'hbe
`define TCC_CMD_COPY       8'h48
`define TCC_CMD_CONVERT    8'h44
`define TCC_CMD_PWR_MODE   8'hb4
`define TCC_CMD_RECALL     8'hb8

`define TCC_CHAIN_OFF      8'h3c
`define TCC_CHAIN_ON       8'h5a
`define TCC_CHAIN_DONE     8'h96

`define TCC_PIO_RESET      2'b11
`define TCC_WR_BITS        7'd24
`define TCC_SP_BITS        7'd64
`define TCC_RD_BITS        7'd72
`define TCC_NV_BYTES       2'd3

`endif

// file: src/tcc_pkg.sv
// types of the thermometer control and chain unit
// assumes nothing beyond the constants header
package tcc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_CMD,
      ST_WR_SP,
      ST_RD_SP,
      ST_COPY,
      ST_CONV,
      ST_RECALL,
      ST_PWR,
      ST_HALT
   } tcc_state_t;

   typedef enum logic [1:0] {
      CH_OFF,
      CH_ON,
      CH_DONE
   } tcc_chain_t;

endpackage : tcc_pkg

// file: src/tcc_crc8.sv
// serial eight-bit check generator, x^8+x^5+x^4+1, lsb first
// assumes clear and shift come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module tcc_crc8 (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       clear,
   input  wire logic       shift,
   input  wire logic       din,
   output logic      [7:0] crc
);

   logic fb;

   assign fb = crc[0] ^ din;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crc <= 8'h00;
      end else if (clear) begin
         crc <= 8'h00;
      end else if (shift) begin
         crc <= {1'b0, crc[7:1]} ^ (fb ? 8'h8c : 8'h00);
      end
   end

endmodule : tcc_crc8

`default_nettype wire

// file: src/tcc_nvm.sv
// small backup memory for alarm thresholds and configuration
// assumes one write or one read per cycle; read data is registered
`timescale 1ns/1ps
`default_nettype none

module tcc_nvm #(
   parameter int unsigned      DEPTH = 3,
   parameter logic [7:0]       INIT0 = 8'h00,
   parameter logic [7:0]       INIT1 = 8'h00,
   parameter logic [7:0]       INIT2 = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       we,
   input  wire logic [1:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [1:0] raddr,
   output logic      [7:0] rdata
);

   logic [7:0] mem_r [DEPTH];

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_cell
         localparam logic [7:0] INIT = (gi == 0) ? INIT0 :
                                       (gi == 1) ? INIT1 : INIT2;
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               mem_r[gi] <= INIT;
            end else if (we && waddr == 2'(gi)) begin
               mem_r[gi] <= wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (32'(raddr) < DEPTH) begin
         rdata <= mem_r[raddr];
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule : tcc_nvm

`default_nettype wire

// file: src/tcc_ctrl.sv
// device function control unit of a single-line bus thermometer
// assumes a bit-level front end on clk giving write and read slot pulses,
// an external converter, and pins that are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_ctrl
   import tcc_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = `TCC_T_PROG_US * `TCC_CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        bus_reset,
   input  wire logic        func_start,
   input  wire logic        wr_valid,
   input  wire logic        wr_bit,
   input  wire logic        rd_slot,
   output logic             rd_valid,
   output logic             rd_bit,
   input  wire logic        od_set,
   output logic             overdrive_flag,
   output logic             cond_rom_enable,
   input  wire logic        chain_req,
   input  wire logic  [7:0] chain_byte,
   output logic             chain_ok,
   output logic       [1:0] chain_state,
   input  wire logic        pio_wr,
   input  wire logic  [1:0] pio_data,
   output logic       [1:0] pio_latch,
   output logic       [1:0] pin_state,
   input  wire logic        port_a_chain_output_in,
   output logic             port_a_chain_output_out,
   output logic             port_a_chain_output_oe,
   output logic             port_a_pullup,
   input  wire logic        port_b_chain_input_in,
   output logic             port_b_chain_input_out,
   output logic             port_b_chain_input_oe,
   input  wire logic        vdd_in,
   output logic             conv_start,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_result,
   output logic       [1:0] resolution,
   output logic       [7:0] conversion_configuration,
   output logic             alarm
);

   localparam int unsigned CW = $clog2(PROG_CYCLES + 4);

   tcc_state_t  state_r;
   tcc_chain_t  chain_r;
   logic [2:0]  pin_meta_r;
   logic [2:0]  pin_sync_r;
   logic        port_b_s;
   logic        vdd_s;
   logic [6:0]  cnt_r;
   logic [7:0]  shift_r;
   logic [7:0]  cmd_nxt;
   logic        byte_end;
   logic        op_start;
   logic [CW-1:0] op_cnt_r;
   logic        op_done_r;
   logic        por_r;
   logic        rec_act;
   logic        copy_act;
   logic [15:0] temp_r;
   logic [7:0]  high_alarm_threshold_r;
   logic [7:0]  low_alarm_threshold_r;
   logic [7:0]  cfg_r;
   logic [7:0]  sp_byte;
   logic        sp_bit;
   logic [7:0]  crc;
   logic        crc_shift;
   logic        nv_we;
   logic [7:0]  nv_wdata;
   logic [7:0]  nv_rdata;
   logic [15:0] res_mask;
   logic        answering;

   // two-flop synchronisers for pins and supply sense
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_r <= 3'h7;
         pin_sync_r <= 3'h7;
      end else begin
         pin_meta_r <= {vdd_in, port_b_chain_input_in,
                        port_a_chain_output_in};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign port_b_s  = pin_sync_r[1];
   assign vdd_s     = pin_sync_r[2];
   assign pin_state = pin_sync_r[1:0];

   assign cmd_nxt  = {wr_bit, shift_r[7:1]};
   assign byte_end = wr_valid && (cnt_r[2:0] == 3'h7);
   assign op_start = (state_r == ST_CMD) && byte_end;
   assign rec_act  = por_r || (state_r == ST_RECALL);
   assign copy_act = (state_r == ST_COPY);

   // command sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else if (bus_reset) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (func_start && !por_r) begin
                  state_r <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (byte_end) begin
                  case (cmd_nxt)
                     `TCC_CMD_WR_SP:    state_r <= ST_WR_SP;
                     `TCC_CMD_RD_SP:    state_r <= ST_RD_SP;
                     `TCC_CMD_COPY:     state_r <= ST_COPY;
                     `TCC_CMD_CONVERT:  state_r <= ST_CONV;
                     `TCC_CMD_PWR_MODE: state_r <= ST_PWR;
                     `TCC_CMD_RECALL:   state_r <= ST_RECALL;
                     default:           state_r <= ST_HALT;
                  endcase
               end
            end
            ST_WR_SP: begin
               if (wr_valid && cnt_r == `TCC_WR_BITS - 7'd1) begin
                  state_r <= ST_HALT;
               end
            end
            default: begin
               state_r <= state_r;
            end
         endcase
      end
   end

   // bit counter and serial shifter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 7'h00;
      end else if (bus_reset || op_start || func_start) begin
         cnt_r <= 7'h00;
      end else if ((state_r == ST_CMD || state_r == ST_WR_SP) && wr_valid) begin
         cnt_r <= cnt_r + 7'h01;
      end else if (state_r == ST_RD_SP && rd_slot
                   && cnt_r != `TCC_RD_BITS) begin
         cnt_r <= cnt_r + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 8'h00;
      end else if (wr_valid) begin
         shift_r <= cmd_nxt;
      end
   end

   // copy, recall and conversion progress
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_cnt_r  <= '0;
         op_done_r <= 1'b0;
      end else if (op_start) begin
         op_cnt_r  <= '0;
         op_done_r <= 1'b0;
      end else if (rec_act && !op_done_r) begin
         if (op_cnt_r == CW'(`TCC_NV_BYTES)) begin
            op_done_r <= 1'b1;
         end else begin
            op_cnt_r <= op_cnt_r + CW'(1);
         end
      end else if (copy_act && !op_done_r) begin
         if (op_cnt_r == CW'(PROG_CYCLES + 2)) begin
            op_done_r <= 1'b1;
         end else begin
            op_cnt_r <= op_cnt_r + CW'(1);
         end
      end else if (state_r == ST_CONV && conv_done) begin
         op_done_r <= 1'b1;
      end
   end

   // automatic recall once after power-on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         por_r <= 1'b1;
      end else if (por_r && op_cnt_r == CW'(`TCC_NV_BYTES)) begin
         por_r <= 1'b0;
      end
   end

   assign nv_we = copy_act && !op_done_r && op_cnt_r < CW'(`TCC_NV_BYTES);
   assign nv_wdata = (op_cnt_r[1:0] == 2'h0) ? high_alarm_threshold_r :
                     (op_cnt_r[1:0] == 2'h1) ? low_alarm_threshold_r : cfg_r;

   tcc_nvm #(
      .DEPTH (3),
      .INIT0 (`TCC_TH_RESET),
      .INIT1 (`TCC_TL_RESET),
      .INIT2 (`TCC_CFG_RESET)
   ) u_nvm (
      .clk   (clk),
      .rstn  (rstn),
      .we    (nv_we),
      .waddr (op_cnt_r[1:0]),
      .wdata (nv_wdata),
      .raddr (op_cnt_r[1:0]),
      .rdata (nv_rdata)
   );

   // user-writable scratchpad bytes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         high_alarm_threshold_r <= `TCC_TH_RESET;
         low_alarm_threshold_r  <= `TCC_TL_RESET;
         cfg_r                  <= `TCC_CFG_RESET;
      end else if (state_r == ST_WR_SP && byte_end) begin
         case (cnt_r[4:3])
            2'h0:    high_alarm_threshold_r <= cmd_nxt;
            2'h1:    low_alarm_threshold_r  <= cmd_nxt;
            2'h2:    cfg_r <= (cmd_nxt & ~`TCC_CFG_FIXED_MASK)
                              | `TCC_CFG_FIXED_VAL;
            default: cfg_r <= cfg_r;
         endcase
      end else if (rec_act && !op_done_r && op_cnt_r != '0) begin
         case (op_cnt_r[1:0])
            2'h1:    high_alarm_threshold_r <= nv_rdata;
            2'h2:    low_alarm_threshold_r  <= nv_rdata;
            2'h3:    cfg_r <= (nv_rdata & ~`TCC_CFG_FIXED_MASK)
                              | `TCC_CFG_FIXED_VAL;
            default: cfg_r <= cfg_r;
         endcase
      end
   end

   assign resolution = cfg_r[`TCC_CFG_RES_HI:`TCC_CFG_RES_LO];
   assign conversion_configuration = cfg_r;

   // undefined fraction bits forced to zero at lower resolution
   always_comb begin
      case (resolution)
         2'h0:    res_mask = 16'hfff8;
         2'h1:    res_mask = 16'hfffc;
         2'h2:    res_mask = 16'hfffe;
         default: res_mask = 16'hffff;
      endcase
   end

   // readout and alarm update at conversion end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp_r <= `TCC_TEMP_RESET;
         alarm  <= 1'b0;
      end else if (conv_done) begin
         temp_r <= conv_result & res_mask;
         alarm  <= ($signed(conv_result[11:4]) >=
                    $signed(high_alarm_threshold_r)) ||
                   ($signed(conv_result[11:4]) <=
                    $signed(low_alarm_threshold_r));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= op_start && cmd_nxt == `TCC_CMD_CONVERT;
      end
   end

   // scratchpad byte selection for serial readout
   always_comb begin
      case (cnt_r[5:3])
         `TCC_SP_TEMP_LSB:    sp_byte = temp_r[7:0];
         `TCC_SP_TEMP_MSB:    sp_byte = temp_r[15:8];
         `TCC_SP_HIGH_ALARM:  sp_byte = high_alarm_threshold_r;
         `TCC_SP_LOW_ALARM:   sp_byte = low_alarm_threshold_r;
         `TCC_SP_CONV_CONFIG: sp_byte = cfg_r;
         `TCC_SP_RSV5:        sp_byte = `TCC_RSV5_VAL;
         `TCC_SP_RSV6:        sp_byte = `TCC_RSV6_VAL;
         default:             sp_byte = `TCC_RSV7_VAL;
      endcase
   end

   assign sp_bit    = sp_byte[cnt_r[2:0]];
   assign crc_shift = (state_r == ST_RD_SP) && rd_slot
                      && cnt_r < `TCC_SP_BITS;

   tcc_crc8 u_crc (
      .clk   (clk),
      .rstn  (rstn),
      .clear (op_start),
      .shift (crc_shift),
      .din   (sp_bit),
      .crc   (crc)
   );

   assign answering = (state_r == ST_RD_SP) || (state_r == ST_COPY) ||
                      (state_r == ST_CONV) || (state_r == ST_RECALL) ||
                      (state_r == ST_PWR);

   // read slot answers, one cycle after the slot pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_valid <= 1'b0;
         rd_bit   <= 1'b1;
      end else begin
         rd_valid <= rd_slot && answering && !bus_reset;
         if (rd_slot) begin
            case (state_r)
               ST_RD_SP: begin
                  if (cnt_r < `TCC_SP_BITS) begin
                     rd_bit <= sp_bit;
                  end else if (cnt_r < `TCC_RD_BITS) begin
                     rd_bit <= crc[cnt_r[2:0]];
                  end else begin
                     rd_bit <= 1'b1;
                  end
               end
               ST_COPY, ST_CONV, ST_RECALL: rd_bit <= op_done_r;
               ST_PWR:  rd_bit <= vdd_s;
               default: rd_bit <= 1'b1;
            endcase
         end
      end
   end

   // chain state, changed only by the chain command
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chain_r  <= CH_OFF;
         chain_ok <= 1'b0;
      end else begin
         chain_ok <= 1'b0;
         if (chain_req) begin
            case (chain_byte)
               `TCC_CHAIN_OFF: begin
                  chain_r  <= CH_OFF;
                  chain_ok <= 1'b1;
               end
               `TCC_CHAIN_ON: begin
                  chain_r  <= CH_ON;
                  chain_ok <= 1'b1;
               end
               `TCC_CHAIN_DONE: begin
                  chain_r  <= CH_DONE;
                  chain_ok <= 1'b1;
               end
               default: chain_r <= chain_r;
            endcase
         end
      end
   end

   assign chain_state = chain_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pio_latch <= `TCC_PIO_RESET;
      end else if (pio_wr && chain_r == CH_OFF) begin
         pio_latch <= pio_data;
      end
   end

   // open-drain drive; with the chain off, a latch bit of 0 turns the pulldown on
   assign port_a_chain_output_out = 1'b0;
   assign port_b_chain_input_out  = 1'b0;
   assign port_a_chain_output_oe  = (chain_r == CH_DONE) ||
                                    (chain_r == CH_OFF && !pio_latch[0]);
   assign port_a_pullup           = (chain_r == CH_ON);
   assign port_b_chain_input_oe   = (chain_r == CH_OFF) && !pio_latch[1];
   assign cond_rom_enable         = (chain_r == CH_ON) && !port_b_s;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         overdrive_flag <= 1'b0;
      end else if (od_set) begin
         overdrive_flag <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   cfg_fixed_a: assert property (
      cfg_r[4:0] == 5'h1f && !cfg_r[7])
      else $error("fixed configuration bits changed");
   chain_hold_a: assert property (
      !chain_req |=> $stable(chain_r))
      else $error("chain state moved without chain command");
   chain_off_a: assert property (
      chain_r == CH_OFF |-> !cond_rom_enable && !port_a_pullup)
      else $error("chain off state enabled chain behaviour");
   chain_on_a: assert property (
      chain_r == CH_ON |-> port_a_pullup && !port_a_chain_output_oe
                           && !port_b_chain_input_oe)
      else $error("chain on output not pulled up");
   cond_rom_a: assert property (
      cond_rom_enable |-> chain_r == CH_ON && !pin_sync_r[1])
      else $error("conditional read enabled wrongly");
   chain_done_a: assert property (
      chain_r == CH_DONE |-> port_a_chain_output_oe
                             && !cond_rom_enable && !port_a_pullup)
      else $error("chain done output not pulled low");
   rd_answer_a: assert property (
      rd_slot && state_r == ST_RD_SP && !bus_reset |=> rd_valid)
      else $error("read slot not answered");
   conv_kick_a: assert property (
      op_start && cmd_nxt == `TCC_CMD_CONVERT
      |=> conv_start ##1 !conv_start)
      else $error("conversion start not a single pulse");
   pwr_sample_a: assert property (
      rd_slot && state_r == ST_PWR |=> rd_bit == $past(vdd_s))
      else $error("power mode answer not supply state");
   od_cause_a: assert property (
      $rose(overdrive_flag) |-> $past(od_set))
      else $error("overdrive set without request");
   halt_hold_a: assert property (
      state_r == ST_HALT && !bus_reset |=> state_r == ST_HALT)
      else $error("unknown command state left without reset");
   alarm_a: assert property (
      conv_done && $signed(conv_result[11:4])
                   >= $signed(high_alarm_threshold_r) |=> alarm)
      else $error("alarm not set above high threshold");

endmodule : tcc_ctrl

`default_nettype wire

// file: bench/tcc_far_model.sv
// far side model: converter and weak pin pull network
// assumes the bench drives pin_b_low for a neighbour pulling the enable low
`timescale 1ns/1ps
`default_nettype none
module tcc_far_model (
   input  wire logic        clk,
   input  wire logic        conv_start,
   input  wire logic        oe_a,
   input  wire logic        oe_b,
   input  wire logic        pin_b_low,
   output logic             conv_done,
   output logic      [15:0] conv_result,
   output logic             pin_a,
   output logic             pin_b
);
   logic [3:0] cnt_r = 4'h0;
   // weak pullups lift both pins unless something pulls low
   assign pin_a = ~oe_a;
   assign pin_b = ~(oe_b | pin_b_low);
   assign conv_done = (cnt_r == 4'h1);
   // result is only valid with the done pulse
   // low fraction bits all set, so every resolution mask shows
   assign conv_result = conv_done ? 16'h0197 : 16'hfe68;
   always_ff @(posedge clk) begin
      if (conv_start) cnt_r <= 4'ha;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
   end
endmodule : tcc_far_model
`default_nettype wire

// file: bench/thermometer_control_and_chain_test.sv
// self-checking bench of the control and chain unit
// assumes tcc_far_model stands for the converter and the pin pulls
`timescale 1ns/1ps
`default_nettype none
module thermometer_control_and_chain_test;
   logic clk = 0, rstn = 0, bus_reset = 0, func_start = 0, wr_valid = 0;
   logic wr_bit = 0, rd_slot = 0, od_set = 0, chain_req = 0, pio_wr = 0;
   logic vdd_in = 1, pin_b_low = 0, b;
   logic [7:0] chain_byte = 8'h00;
   logic [1:0] pio_data = 2'b11;
   logic rd_valid, rd_bit, overdrive_flag, cond_rom_enable, chain_ok, alarm;
   logic pa_in, pa_out, pa_oe, pa_up, pb_in, pb_out, pb_oe;
   logic conv_start, conv_done;
   logic [1:0] chain_state, pio_latch, pin_state, resolution;
   logic [15:0] conv_result;
   logic [7:0] cfg;
   logic [71:0] sp;
   int err_count = 0, n_checks = 0;
   tcc_ctrl #(.PROG_CYCLES(20)) dut (.clk, .rstn, .bus_reset, .func_start,
      .wr_valid, .wr_bit, .rd_slot, .rd_valid, .rd_bit, .od_set,
      .overdrive_flag, .cond_rom_enable, .chain_req, .chain_byte, .chain_ok,
      .chain_state, .pio_wr, .pio_data, .pio_latch, .pin_state,
      .port_a_chain_output_in(pa_in), .port_a_chain_output_out(pa_out),
      .port_a_chain_output_oe(pa_oe), .port_a_pullup(pa_up),
      .port_b_chain_input_in(pb_in), .port_b_chain_input_out(pb_out),
      .port_b_chain_input_oe(pb_oe), .vdd_in, .conv_start, .conv_done,
      .conv_result, .resolution, .conversion_configuration(cfg), .alarm);
   tcc_far_model far (.clk, .conv_start, .oe_a(pa_oe), .oe_b(pb_oe),
      .pin_b_low, .conv_done, .conv_result, .pin_a(pa_in), .pin_b(pb_in));
   initial forever #10 clk = ~clk;
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // x^8+x^5+x^4+1 fed lsb first; data plus its check byte leaves zero
   function automatic logic [7:0] crc8(input logic [71:0] d);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 72; i++) begin
         fb = c[0] ^ d[i];
         c = {fb, c[7:1]};
         c[3] = c[3] ^ fb;
         c[2] = c[2] ^ fb;
      end
      return c;
   endfunction : crc8
   // leaves wr_valid high so bytes follow back to back
   task automatic wr8(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         wr_valid = 1;
         wr_bit = d[i];
         tick();
      end
   endtask : wr8
   task automatic cmd(input logic [7:0] c);
      bus_reset = 1;
      tick();
      bus_reset = 0;
      func_start = 1;
      tick();
      func_start = 0;
      wr8(c);
   endtask : cmd
   task automatic slot(output logic v);
      wr_valid = 0;
      rd_slot = 1;
      tick();
      rd_slot = 0;
      chk(rd_valid, 1'b1);
      v = rd_bit;
      tick();
   endtask : slot
   task automatic wrsp(input logic [7:0] th, input logic [7:0] tl,
                       input logic [7:0] c);
      cmd(8'h4e);
      wr8(th);
      wr8(tl);
      wr8(c);
      wr_valid = 0;
      tick();
   endtask : wrsp
   task automatic busy(input logic [7:0] c);
      cmd(c);
      slot(b);
      chk(b, 1'b0);
      for (int i = 0; i < 40 && b !== 1'b1; i++) slot(b);
      chk(b, 1'b1);
   endtask : busy
   task automatic chain(input logic [7:0] c, input logic ok);
      chain_byte = c;
      chain_req = 1;
      tick();
      chain_req = 0;
      chk(chain_ok, ok);
      tick();
   endtask : chain
   task automatic pio(input logic [1:0] d);
      pio_data = d;
      pio_wr = 1;
      tick();
      pio_wr = 0;
      tick(3);
   endtask : pio
   task automatic t_memory;
      wrsp(8'h18, 8'h00, 8'h00);
      chk({cfg, resolution}, {8'h1f, 2'h0});
      busy(8'h44);
      chk(alarm, 1'b1);
      cmd(8'hbe);
      for (int i = 0; i < 72; i++) slot(sp[i]);
      chk(sp[63:0], 64'h100cff1f00180190);
      chk(crc8(sp), 8'h00);
      busy(8'h48);
      wrsp(8'h7f, 8'h80, 8'hc0);
      chk({cfg, resolution}, {8'h5f, 2'h2});
      busy(8'h44);
      chk(alarm, 1'b0);
      cmd(8'hbe);
      for (int i = 0; i < 16; i++) slot(sp[i]);
      chk(sp[15:0], 16'h0196);
      busy(8'hb8);
      chk({cfg, resolution}, {8'h1f, 2'h0});
   endtask : t_memory
   task automatic t_chain;
      pio(2'b10);
      chk({pio_latch, pa_oe, pb_oe, pin_state}, 6'h2a);
      pio(2'b11);
      chain(8'h5a, 1'b1);
      pio(2'b00);
      chk({chain_state, pio_latch, pa_up, cond_rom_enable}, 6'h1e);
      pin_b_low = 1;
      tick(3);
      chk(cond_rom_enable, 1'b1);
      chain(8'h96, 1'b1);
      chk({chain_state, pa_oe, cond_rom_enable}, 4'ha);
      chain(8'h33, 1'b0);
      chk(chain_state, 2'h2);
      chain(8'h3c, 1'b1);
      pin_b_low = 0;
      chk({chain_state, pa_oe, pa_up}, 4'h0);
   endtask : t_chain
   task automatic t_misc;
      cmd(8'hb4);
      slot(b);
      chk(b, 1'b1);
      vdd_in = 0;
      tick(3);
      slot(b);
      chk(b, 1'b0);
      cmd(8'ha0);
      wr_valid = 0;
      rd_slot = 1;
      tick();
      rd_slot = 0;
      chk(rd_valid, 1'b0);
      od_set = 1;
      tick();
      od_set = 0;
      tick();
      chk(overdrive_flag, 1'b1);
   endtask : t_misc
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      tick(10);
      rstn = 1;
      tick(6);
      chk({cfg, resolution}, {8'h7f, 2'h3});
      chk({pio_latch, pa_oe, pb_oe, chain_state, pa_out, pb_out},
          8'hc0);
      chk(overdrive_flag, 1'b0);
      t_memory();
      t_chain();
      t_misc();
      wrap_up();
   end
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
endmodule : thermometer_control_and_chain_test
`default_nettype wire
